/* design/dsp_defines.svh */
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH

// Word and address widths of the default 8-bit variant
`define DSP_DW_DEF       8
`define DSP_AW_DEF       22
`define DSP_SW_DEF       2
// Lane widths for write selects
`define DSP_NIB_W        4
`define DSP_LANE_W       9
`define DSP_NIB_DW       8
// Controller clock cycles per half period of the input timing pair
`define DSP_HALF_DEF     2
// Launch edges from load to first read beat, plus one
`define DSP_LAT_DLL_ON   3'h4
`define DSP_LAT_DLL_OFF  3'h3
`define DSP_CNT_ONE      3'h1
`define DSP_CNT_ZERO     3'h0
// Read slots in flight at once
`define DSP_SLOTS        2

`endif

/* design/dsp_pkg.sv */
package dsp_pkg;
    typedef enum logic {
        DSP_WRITE,
        DSP_READ
    } dsp_dir_t;
endpackage

/* design/dsp_if.sv */
`timescale 1ns/100ps
interface dsp_if #(
    parameter int DW = 8,
    parameter int AW = 22,
    parameter int SW = 2
);
    import dsp_pkg::*;
    logic            input_timing_p;
    logic            input_timing_n;
    logic            output_timing_p;
    logic            output_timing_n;
    logic            load_strobe_n;
    dsp_dir_t        access_dir;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
    logic [SW-1:0]   write_sel_n;
    logic            single_clk_mode;
    logic            dll_off_n;
    logic [DW-1:0]   rdata;
    logic            rdata_oe_n;
    logic            echo_timing_p;

    modport dev (
        input  input_timing_p, input_timing_n, output_timing_p, output_timing_n,
        input  load_strobe_n, access_dir, addr, wdata, write_sel_n,
        input  single_clk_mode, dll_off_n,
        output rdata, rdata_oe_n, echo_timing_p
    );
    modport ctl (
        output input_timing_p, input_timing_n, output_timing_p, output_timing_n,
        output load_strobe_n, access_dir, addr, wdata, write_sel_n,
        output single_clk_mode, dll_off_n,
        input  rdata, rdata_oe_n, echo_timing_p
    );
endinterface

/* design/dsp_device.sv */
`timescale 1ns/100ps
`include "dsp_defines.svh"
module dsp_device #(
    parameter int DW = `DSP_DW_DEF,
    parameter int AW = `DSP_AW_DEF,
    parameter int SW = `DSP_SW_DEF
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    dsp_if.dev         port,
    output logic       access_seen,
    output logic       dll_bypassed
);
    import dsp_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic                  kp_q;
        logic                  kn_q;
        logic                  lp_q;
        logic                  ln_q;
        logic                  w0_pend;
        logic [AW-1:0]         w0_addr;
        logic                  w1_pend;
        logic [AW-1:0]         w1_addr;
        logic [1:0]            sv;
        logic [1:0][2:0]       cnt;
        logic [1:0][DW-1:0]    rd0;
        logic [1:0][DW-1:0]    rd1;
        logic                  slot;
        logic [DW-1:0]         q;
        logic                  q_oe_n;
        logic                  echo;
        logic                  seen;
        logic                  dll_off;
    } dsp_dev_st_t;

    dsp_dev_st_t r;
    dsp_dev_st_t n;

    // Two arrays, one per beat
    logic [DW-1:0] mem_beat0 [0:(1<<AW)-1];
    logic [DW-1:0] mem_beat1 [0:(1<<AW)-1];

    logic          we0;
    logic          we1;
    logic [AW-1:0] wa0;
    logic [AW-1:0] wa1;
    logic [DW-1:0] wd;
    logic [DW-1:0] wm;
    logic          kp_rise;
    logic          kn_rise;
    logic          lp;
    logic          ln;
    logic          launch;
    logic [2:0]    cdec;

    // --------------------------------------------------------------
    // Write select to bit mask
    // --------------------------------------------------------------
    function automatic logic [DW-1:0] lane_mask(input logic [SW-1:0] sel_n);
        int lane;
        lane_mask = '0;
        for (int b = 0; b < DW; b++) begin
            if (DW == `DSP_NIB_DW) begin
                lane = b / `DSP_NIB_W;
            end else begin
                lane = b / `DSP_LANE_W;
            end
            lane_mask[b] = ~sel_n[lane];
        end
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        n       = r;
        n.seen  = 1'b0;
        we0     = 1'b0;
        we1     = 1'b0;
        wa0     = r.w0_addr;
        wa1     = r.w1_addr;
        wd      = port.wdata;
        wm      = lane_mask(port.write_sel_n);
        cdec    = `DSP_CNT_ZERO;

        n.kp_q  = port.input_timing_p;
        n.kn_q  = port.input_timing_n;
        kp_rise = port.input_timing_p & ~r.kp_q;
        kn_rise = port.input_timing_n & ~r.kn_q;

        if (port.single_clk_mode) begin
            lp = port.input_timing_p;
            ln = port.input_timing_n;
        end else begin
            lp = port.output_timing_p;
            ln = port.output_timing_n;
        end
        n.lp_q  = lp;
        n.ln_q  = ln;
        launch  = (lp & ~r.lp_q) | (ln & ~r.ln_q);
        n.echo  = lp;
        n.dll_off = ~port.dll_off_n;

        // Write beats: first on rising edge, second on falling-phase edge
        if (kp_rise && r.w0_pend) begin
            we0       = 1'b1;
            n.w0_pend = 1'b0;
            n.w1_pend = 1'b1;
            n.w1_addr = r.w0_addr;
        end
        if (kn_rise && r.w1_pend) begin
            we1       = 1'b1;
            n.w1_pend = 1'b0;
        end

        // Read launch; idle edges release the bus
        if (launch) begin
            n.q_oe_n = 1'b1;
            for (int i = 0; i < `DSP_SLOTS; i++) begin
                if (r.sv[i]) begin
                    cdec     = r.cnt[i] - `DSP_CNT_ONE;
                    n.cnt[i] = cdec;
                    if (cdec == `DSP_CNT_ONE) begin
                        n.q      = r.rd0[i];
                        n.q_oe_n = 1'b0;
                    end else if (cdec == `DSP_CNT_ZERO) begin
                        n.q      = r.rd1[i];
                        n.q_oe_n = 1'b0;
                        n.sv[i]  = 1'b0;
                    end
                end
            end
        end

        // New transaction; address used only when selected
        if (kp_rise && !port.load_strobe_n) begin
            n.seen = 1'b1;
            if (port.access_dir == DSP_READ) begin
                n.sv[r.slot]  = 1'b1;
                n.rd0[r.slot] = mem_beat0[port.addr];
                n.rd1[r.slot] = mem_beat1[port.addr];
                n.cnt[r.slot] = port.dll_off_n ? `DSP_LAT_DLL_ON
                                               : `DSP_LAT_DLL_OFF;
                n.slot        = ~r.slot;
            end else begin
                n.w0_pend = 1'b1;
                n.w0_addr = port.addr;
            end
        end
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.q_oe_n <= 1'b1;
            r.kn_q   <= 1'b1;
            r.ln_q   <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Masked writes leave unselected lanes untouched
    always_ff @(posedge clk) begin
        if (we0) begin
            mem_beat0[wa0] <= (mem_beat0[wa0] & ~wm) | (wd & wm);
        end
        if (we1) begin
            mem_beat1[wa1] <= (mem_beat1[wa1] & ~wm) | (wd & wm);
        end
    end

    assign port.rdata         = r.q;
    assign port.rdata_oe_n    = r.q_oe_n;
    assign port.echo_timing_p = r.echo;
    assign access_seen        = r.seen;
    assign dll_bypassed       = r.dll_off;
endmodule

/* design/dsp_ctrl.sv */
`timescale 1ns/100ps
`include "dsp_defines.svh"
module dsp_ctrl #(
    parameter int DW   = `DSP_DW_DEF,
    parameter int AW   = `DSP_AW_DEF,
    parameter int SW   = `DSP_SW_DEF,
    parameter int HALF = `DSP_HALF_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    dsp_if.ctl                     port,
    input  wire logic              req_valid,
    input  wire dsp_pkg::dsp_dir_t req_dir,
    input  wire logic [AW-1:0]     req_addr,
    input  wire logic [DW-1:0]     req_wdata0,
    input  wire logic [DW-1:0]     req_wdata1,
    input  wire logic [SW-1:0]     req_sel0_n,
    input  wire logic [SW-1:0]     req_sel1_n,
    input  wire logic              cfg_single_clk,
    input  wire logic              cfg_dll_off_n,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DW-1:0]          rsp_data0,
    output logic [DW-1:0]          rsp_data1
);
    import dsp_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    div;
        logic          kp;
        logic          kn;
        logic          cp;
        logic          cn;
        logic          ld_n;
        dsp_dir_t      dir;
        logic [AW-1:0] addr;
        logic [DW-1:0] wd;
        logic [SW-1:0] ws_n;
        logic          pend;
        dsp_dir_t      p_dir;
        logic [AW-1:0] p_addr;
        logic [DW-1:0] p_d0;
        logic [DW-1:0] p_d1;
        logic [SW-1:0] p_s0;
        logic [SW-1:0] p_s1;
        logic          s_v;
        logic [DW-1:0] s_d0;
        logic [DW-1:0] s_d1;
        logic [SW-1:0] s_s0;
        logic [SW-1:0] s_s1;
        logic [DW-1:0] b1_d;
        logic [SW-1:0] b1_s;
        logic          ready;
        logic          echo_q;
        logic          beat;
        logic          rv;
        logic [DW-1:0] r0;
        logic [DW-1:0] r1;
        logic          single;
        logic          dll_n;
    } dsp_ctl_st_t;

    dsp_ctl_st_t r;
    dsp_ctl_st_t n;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        n        = r;
        n.rv     = 1'b0;
        n.single = cfg_single_clk;
        n.dll_n  = cfg_dll_off_n;

        if (r.div == 8'(HALF - 1)) begin
            n.div = '0;
            n.kp  = ~r.kp;
            n.kn  = r.kp;
            // Output pair follows input pair, held high in single clock mode; no flight-time skew applied
            n.cp  = r.single | ~r.kp;
            n.cn  = r.single | r.kp;
            if (!r.kp) begin
                n.ld_n = ~r.pend;
                n.dir  = r.p_dir;
                n.addr = r.p_addr;
                n.wd   = r.s_d0;
                n.ws_n = r.s_v ? r.s_s0 : '1;
                n.b1_d = r.s_d1;
                n.b1_s = r.s_v ? r.s_s1 : '1;
                n.s_v  = r.pend && (r.p_dir == DSP_WRITE);
                n.s_d0 = r.p_d0;
                n.s_d1 = r.p_d1;
                n.s_s0 = r.p_s0;
                n.s_s1 = r.p_s1;
                n.pend = 1'b0;
            end else begin
                n.wd   = r.b1_d;
                n.ws_n = r.b1_s;
            end
        end else begin
            n.div = r.div + 8'h01;
        end

        if (req_valid && r.ready) begin
            n.pend   = 1'b1;
            n.p_dir  = req_dir;
            n.p_addr = req_addr;
            n.p_d0   = req_wdata0;
            n.p_d1   = req_wdata1;
            n.p_s0   = req_sel0_n;
            n.p_s1   = req_sel1_n;
        end
        n.ready = ~n.pend;

        // Each echo transition marks one launched beat
        n.echo_q = port.echo_timing_p;
        if ((port.echo_timing_p != r.echo_q) && !port.rdata_oe_n) begin
            if (!r.beat) begin
                n.r0   = port.rdata;
                n.beat = 1'b1;
            end else begin
                n.r1   = port.rdata;
                n.beat = 1'b0;
                n.rv   = 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.ld_n  <= 1'b1;
            r.ws_n  <= '1;
            r.b1_s  <= '1;
            r.kn    <= 1'b1;
            r.cn    <= 1'b1;
            r.ready <= 1'b1;
            r.dll_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign port.input_timing_p  = r.kp;
    assign port.input_timing_n  = r.kn;
    assign port.output_timing_p = r.cp;
    assign port.output_timing_n = r.cn;
    assign port.load_strobe_n   = r.ld_n;
    assign port.access_dir      = r.dir;
    assign port.addr            = r.addr;
    assign port.wdata           = r.wd;
    assign port.write_sel_n     = r.ws_n;
    assign port.single_clk_mode = r.single;
    assign port.dll_off_n       = r.dll_n;
    assign req_ready            = r.ready;
    assign rsp_valid            = r.rv;
    assign rsp_data0            = r.r0;
    assign rsp_data1            = r.r1;
endmodule

/* test/dsp_assertions.sv */
`timescale 1ns/100ps
module dsp_assertions #(
    parameter int SW = 2
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              input_timing_p,
    input wire logic              output_timing_p,
    input wire logic              output_timing_n,
    input wire logic              load_strobe_n,
    input wire dsp_pkg::dsp_dir_t access_dir,
    input wire logic [SW-1:0]     write_sel_n,
    input wire logic              single_clk_mode,
    input wire logic              dll_off_n,
    input wire logic              rdata_oe_n,
    input wire logic              echo_timing_p
);
    import dsp_pkg::*;
    logic       k_prev_r;
    logic [4:0] rd_age_r;
    logic [4:0] wr_age_r;
    wire        k_up = input_timing_p && !k_prev_r;

    // Cycles since the last read or write load, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            k_prev_r <= 1'b0;
            rd_age_r <= 5'h1F;
            wr_age_r <= 5'h1F;
        end else begin
            k_prev_r <= input_timing_p;
            if (k_up && !load_strobe_n && access_dir == DSP_READ) begin
                rd_age_r <= 5'h00;
            end else if (rd_age_r != 5'h1F) begin
                rd_age_r <= rd_age_r + 5'h01;
            end
            if (k_up && !load_strobe_n && access_dir == DSP_WRITE) begin
                wr_age_r <= 5'h00;
            end else if (wr_age_r != 5'h1F) begin
                wr_age_r <= wr_age_r + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence read_load;
        k_up && !load_strobe_n && access_dir == DSP_READ;
    endsequence
    sequence write_load;
        k_up && !load_strobe_n && access_dir == DSP_WRITE;
    endsequence

    chk_ld_on_rise: assert property ($fell(load_strobe_n) |-> $rose(input_timing_p))
        else $error("load strobe fell away from a K rise");
    chk_k_period: assert property ($rose(input_timing_p) |=> input_timing_p ##1 !input_timing_p)
        else $error("K high phase not two cycles");
    chk_read_drives: assert property (read_load |-> ##[2:12] !rdata_oe_n)
        else $error("read load gave no read data");
    chk_dll_off_fast: assert property (read_load ##0 (!dll_off_n && !$past(dll_off_n))
        |-> ##[2:8] !rdata_oe_n)
        else $error("read data late with DLL off");
    chk_oe_two_beats: assert property ($fell(rdata_oe_n) |-> (!rdata_oe_n)[*4])
        else $error("read burst shorter than two beats");
    chk_oe_idle_off: assert property (rd_age_r >= 5'h10 |-> rdata_oe_n)
        else $error("read data driven while read port idle");
    chk_write_quiet: assert property ((rd_age_r >= 5'h10) and write_load |-> rdata_oe_n[*8])
        else $error("write load drove read data");
    chk_wsel_idle: assert property (wr_age_r >= 5'h0C |-> write_sel_n == {SW{1'b1}})
        else $error("write select active outside a write");
    chk_echo_free: assert property ($rose(echo_timing_p) && single_clk_mode == $past(single_clk_mode, 4)
        |=> echo_timing_p ##1 !echo_timing_p)
        else $error("echo clock not free running");
    chk_single_c_held: assert property (single_clk_mode[*3] |-> output_timing_p && output_timing_n)
        else $error("output pair not held in single clock mode");
endmodule

/* test/tb_ddr_sio_sram_port.sv */
`timescale 1ns/100ps
module tb_ddr_sio_sram_port;
    import dsp_pkg::*;
    logic       clk;
    logic       rst_n;
    logic       req_valid;
    dsp_dir_t   req_dir;
    logic [5:0] req_addr;
    logic [7:0] req_wdata0;
    logic [7:0] req_wdata1;
    logic [1:0] req_sel0_n;
    logic [1:0] req_sel1_n;
    logic       cfg_single_clk;
    logic       cfg_dll_off_n;
    logic       req_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data0;
    logic [7:0] rsp_data1;
    logic       access_seen;
    logic       dll_bypassed;
    int         errors;
    int         compares;
    int         sent_cnt;
    int         seen_cnt;

    dsp_if #(.AW(6)) link ();
    dsp_ctrl #(.AW(6)) dsp_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .port(link), .req_valid(req_valid), .req_dir(req_dir),
        .req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
        .req_sel0_n(req_sel0_n), .req_sel1_n(req_sel1_n), .cfg_single_clk(cfg_single_clk),
        .cfg_dll_off_n(cfg_dll_off_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data0(rsp_data0), .rsp_data1(rsp_data1));
    dsp_device #(.AW(6)) dsp_device_inst (
        .clk(clk), .rst_n(rst_n), .port(link), .access_seen(access_seen),
        .dll_bypassed(dll_bypassed));
    dsp_assertions dsp_assertions_inst (
        .clk(clk), .rst_n(rst_n), .input_timing_p(link.input_timing_p),
        .output_timing_p(link.output_timing_p), .output_timing_n(link.output_timing_n),
        .load_strobe_n(link.load_strobe_n), .access_dir(link.access_dir),
        .write_sel_n(link.write_sel_n), .single_clk_mode(link.single_clk_mode),
        .dll_off_n(link.dll_off_n), .rdata_oe_n(link.rdata_oe_n),
        .echo_timing_p(link.echo_timing_p));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (access_seen === 1'b1) begin
            seen_cnt++;
        end
    end

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input dsp_dir_t dir, input logic [5:0] a, input logic [7:0] d0,
                        input logic [7:0] d1, input logic [1:0] s0, input logic [1:0] s1);
        int n;
        @(posedge clk);
        req_valid  <= 1'b1;
        req_dir    <= dir;
        req_addr   <= a;
        req_wdata0 <= d0;
        req_wdata1 <= d1;
        req_sel0_n <= s0;
        req_sel1_n <= s1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("[FAIL] %0t: request not taken", $time);
        end
        req_valid <= 1'b0;
        sent_cnt++;
    endtask

    task automatic expect_rsp(input logic [7:0] e0, input logic [7:0] e1);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 60);
        if (n >= 60) begin
            errors++;
            $display("[FAIL] %0t: no read response", $time);
        end
        check(rsp_data0, e0);
        check(rsp_data1, e1);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d0, input logic [7:0] d1,
                      input logic [1:0] s0, input logic [1:0] s1);
        send(DSP_WRITE, a, d0, d1, s0, s1);
        repeat (8) @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e0, input logic [7:0] e1);
        send(DSP_READ, a, 8'h00, 8'h00, 2'b11, 2'b11);
        expect_rsp(e0, e1);
    endtask

    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_dir = DSP_WRITE;
        req_addr = 6'h00;
        req_wdata0 = 8'h00;
        req_wdata1 = 8'h00;
        req_sel0_n = 2'b11;
        req_sel1_n = 2'b11;
        cfg_single_clk = 1'b0;
        cfg_dll_off_n = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wr(6'h05, 8'h3C, 8'hA5, 2'b00, 2'b00);
        rd(6'h05, 8'h3C, 8'hA5);
        $display("test 1 burst write and read done");
        wr(6'h05, 8'hFF, 8'hFF, 2'b01, 2'b10);
        rd(6'h05, 8'hFC, 8'hAF);
        $display("test 2 nibble selects done");
        wr(6'h05, 8'h00, 8'h00, 2'b11, 2'b11);
        rd(6'h05, 8'hFC, 8'hAF);
        $display("test 3 masked write done");
        wr(6'h06, 8'h12, 8'h34, 2'b00, 2'b00);
        send(DSP_READ, 6'h05, 8'h00, 8'h00, 2'b11, 2'b11);
        send(DSP_READ, 6'h06, 8'h00, 8'h00, 2'b11, 2'b11);
        expect_rsp(8'hFC, 8'hAF);
        expect_rsp(8'h12, 8'h34);
        $display("test 4 back to back reads done");
        cfg_dll_off_n <= 1'b0;
        repeat (4) @(posedge clk);
        check({7'h00, dll_bypassed}, 8'h01);
        rd(6'h06, 8'h12, 8'h34);
        cfg_dll_off_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test 5 DLL off done");
        cfg_single_clk <= 1'b1;
        repeat (4) @(posedge clk);
        rd(6'h05, 8'hFC, 8'hAF);
        wr(6'h07, 8'h5A, 8'hC3, 2'b00, 2'b00);
        rd(6'h07, 8'h5A, 8'hC3);
        cfg_single_clk <= 1'b0;
        repeat (20) @(posedge clk);
        check(seen_cnt[7:0], sent_cnt[7:0]);
        $display("test 6 single clock and load count done");
        final_report();
    end

    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        final_report();
    end
endmodule
